//--- common/sfc_pkg.sv
// Constants and types for the serial flash status and identification block.
// Assumes a 50 MHz system clock and a host clock well below a quarter of it.
package sfc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SFC_CLK_MHZ = 50;
  localparam int unsigned SFC_TW_NS = 10000;
  localparam int unsigned SFC_TW_CYCLES = (SFC_TW_NS * SFC_CLK_MHZ) / 1000;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WR_EN = 8'h06;
  localparam logic [7:0] CMD_VOL_EN = 8'h50;
  localparam logic [7:0] CMD_WR_DIS = 8'h04;
  localparam logic [7:0] CMD_RD_SR1 = 8'h05;
  localparam logic [7:0] CMD_RD_SR2 = 8'h35;
  localparam logic [7:0] CMD_WR_SR = 8'h01;
  localparam logic [7:0] CMD_PROG = 8'h02;
  localparam logic [7:0] CMD_QPROG = 8'h32;
  localparam logic [7:0] CMD_ER4K = 8'h20;
  localparam logic [7:0] CMD_ER32K = 8'h52;
  localparam logic [7:0] CMD_ER64K = 8'hd8;
  localparam logic [7:0] CMD_CHIP_ER = 8'hc7;
  localparam logic [7:0] CMD_CHIP_ER2 = 8'h60;
  localparam logic [7:0] CMD_SEC_ER = 8'h44;
  localparam logic [7:0] CMD_SEC_PROG = 8'h42;
  localparam logic [7:0] CMD_SEC_RD = 8'h48;
  localparam logic [7:0] CMD_ID = 8'hab;
  localparam logic [7:0] CMD_MFID = 8'h90;
  localparam logic [7:0] CMD_MFID_D = 8'h92;
  localparam logic [7:0] CMD_MFID_Q = 8'h94;
  localparam logic [7:0] CMD_RD_DIO = 8'hbb;
  localparam logic [7:0] CMD_RD_QIO = 8'heb;
  localparam logic [7:0] CMD_RD_QWD = 8'he7;
  localparam logic [7:0] CMD_RD_QOW = 8'he3;
  localparam logic [7:0] CMD_WRAP = 8'h77;

  // ----------------------------------------------------------------
  // Phase lengths in bits or clocks
  // ----------------------------------------------------------------
  localparam logic [5:0] SFC_CMD_LEN = 6'd8;
  localparam logic [5:0] SFC_ADDR_LEN = 6'd24;
  localparam logic [5:0] SFC_ADDR_MODE_LEN = 6'd32;
  localparam logic [5:0] SFC_WRSR_SHORT = 6'd16;
  localparam logic [5:0] SFC_WRSR_LONG = 6'd24;
  localparam logic [5:0] SFC_PROG_MIN = 6'd40;
  localparam logic [3:0] SFC_DUMMY_QIO = 4'd4;
  localparam logic [3:0] SFC_DUMMY_QWD = 4'd2;
  localparam logic [3:0] SFC_DUMMY_QID = 4'd2;
  localparam logic [3:0] SFC_DUMMY_SEC = 4'd8;
  localparam int SFC_WRAP_LSB = 4;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam logic [7:0] SFC_SR1_RST = 8'h00;
  localparam logic [7:0] SFC_SR2_RST = 8'h00;
  localparam logic [7:0] SFC_SR1_WR_MASK = 8'hfc;
  localparam logic [7:0] SFC_SR2_WR_MASK = 8'h7b;
  localparam logic [7:0] SFC_SR2_OTP_MASK = 8'h39;
  localparam logic [7:0] SFC_SR2_CLR8_MASK = 8'h42;
  localparam int SFC_QE_BIT = 1;
  localparam logic [7:0] SFC_SEC_PAGE1 = 8'h10;
  localparam logic [7:0] SFC_SEC_PAGE2 = 8'h20;
  localparam logic [7:0] SFC_SEC_PAGE3 = 8'h30;
  localparam logic [3:0] SFC_OE_1 = 4'h2;
  localparam logic [3:0] SFC_OE_2 = 4'h3;
  localparam logic [3:0] SFC_OE_4 = 4'hf;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_CMD = 3'h0, ST_ADDR = 3'h1, ST_DUMMY = 3'h2,
    ST_OUT = 3'h3, ST_WDATA = 3'h4, ST_SKIP = 3'h5
  } sfc_state_t;
  typedef enum logic [1:0] {LANE_1 = 2'h0, LANE_2 = 2'h1, LANE_4 = 2'h2} sfc_lane_t;
  typedef enum logic [2:0] {
    SRC_NONE = 3'h0, SRC_SR1 = 3'h1, SRC_SR2 = 3'h2,
    SRC_PART = 3'h3, SRC_PAIR = 3'h4, SRC_ARRAY = 3'h5
  } sfc_src_t;

  typedef struct packed {
    sfc_state_t st;
    sfc_lane_t lw;
    logic [5:0] alen;
    logic [3:0] dlen;
    sfc_src_t src;
    logic go;
  } sfc_dec_t;

  typedef struct packed {
    sfc_state_t state;
    sfc_lane_t lw;
    sfc_src_t src;
    logic [2:0] sck;
    logic [2:0] cs;
    logic [1:0][3:0] io;
    logic [7:0] cmd;
    logic go;
    logic [31:0] sh;
    logic [5:0] cnt;
    logic [5:0] alen;
    logic [3:0] dlen;
    logic [23:0] addr;
    logic [7:0] osh;
    logic [3:0] ocnt;
    logic idsel;
    logic [5:0] tot;
    logic [2:0] bnd;
    logic write_enable_latch;
    logic varm;
    logic [7:0] v1;
    logic [7:0] v2;
    logic [7:0] nv1;
    logic [7:0] nv2;
    logic [7:0] p1;
    logic [7:0] p2;
    logic busy;
    logic [15:0] bcnt;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic rd_start;
    logic [23:0] rd_addr;
    logic op_start;
    logic [7:0] op_code;
    logic [23:0] op_addr;
    logic [2:0] wrap;
  } sfc_regs_t;

  localparam sfc_regs_t SFC_REGS_RST = '{
    state: ST_CMD, lw: LANE_1, src: SRC_NONE, cs: 3'h7,
    v1: SFC_SR1_RST, v2: SFC_SR2_RST, nv1: SFC_SR1_RST, nv2: SFC_SR2_RST,
    default: '0
  };

endpackage

//--- tb/sfc_host.sv
// Host controller model for the flash instruction block: chip select, clock, lanes.
// Assumes it is stepped from clk's falling edge; the bench calls its tasks.
`timescale 1ns/1ps
module sfc_host (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output wire logic [3:0] io_in,
  input wire logic [3:0] io_out
);
  // ----------------------------------------------------------------
  // Lane drive
  // ----------------------------------------------------------------
  logic drv;
  logic [3:0] val;
  logic [3:0] jnk;
  // Released lanes toggle so stale data cannot pass for valid
  assign io_in = drv ? val : jnk;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    drv = 1'b0;
    val = 4'h0;
    jnk = 4'h5;
  end
  always @(negedge clk) begin
    jnk <= ~jnk;
  end
  // ----------------------------------------------------------------
  // Framing and shifting
  // ----------------------------------------------------------------
  task automatic hold_clk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic open_f();
    cs_n = 1'b0;
    hold_clk(4);
  endtask
  task automatic close_f();
    drv = 1'b0;
    hold_clk(4);
    cs_n = 1'b1;
    hold_clk(8);
  endtask
  // High bit on the highest lane in use
  task automatic send(input logic [63:0] d, input int n, input int w);
    for (int i = 0; i < n; i++) begin
      drv = 1'b1;
      val = d[63:60] >> (4 - w);
      d = d << w;
      hold_clk(4);
      sclk = 1'b1;
      hold_clk(4);
      sclk = 1'b0;
    end
  endtask
  task automatic recv(input int n, input int w, output logic [31:0] q);
    q = '0;
    drv = 1'b0;
    for (int i = 0; i < n; i++) begin
      hold_clk(4);
      sclk = 1'b1;
      hold_clk(4);
      q = (q << w) | ((w == 1) ? 32'(io_out[1]) : 32'(io_out & 4'((1 << w) - 1)));
      sclk = 1'b0;
    end
  endtask
endmodule

//--- tb/sfc_top_tb.sv
// Self-checking bench for the flash instruction block.
// Assumes the host model drives the link; the bench plays the array side.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module sfc_top_tb
  import sfc_pkg::*;
;
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  localparam logic [7:0] MK = 8'h96; // Arbitrary value
  localparam logic [7:0] PT = 8'h69; // Arbitrary value
  logic clk, reset_n, cs_n, sclk, arr_busy, op_done, arr_valid, arr_ready;
  logic rd_start, op_start;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] arr_data, op_code;
  logic [23:0] rd_addr, op_addr;
  logic [2:0] wrap_bits;
  int n_fail = 0;
  int tests_run = 0;
  int n_op = 0;
  always @(negedge clk) if (op_start === 1'b1) n_op <= n_op + 1;
  sfc_top #(.TW_CYCLES(400), .MAKER_CODE(MK), .PART_CODE(PT)) uut (.clk(clk),
    .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .arr_busy(arr_busy), .op_done(op_done), .arr_valid(arr_valid),
    .arr_data(arr_data), .arr_ready(arr_ready), .rd_start(rd_start), .rd_addr(rd_addr),
    .op_start(op_start), .op_code(op_code), .op_addr(op_addr), .wrap_bits(wrap_bits));
  sfc_host h (.clk(clk), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic fr(input logic [7:0] c, input logic [63:0] d, input int n, w, nr, rw,
      output logic [31:0] q);
    q = '0;
    h.open_f();
    h.send({c, 56'h0}, 8, 1);
    if (n > 0) h.send(d, n, w);
    if (nr > 0) h.recv(nr, rw, q);
    h.close_f();
  endtask
  task automatic rd(input logic [7:0] c, output logic [31:0] q);
    fr(c, '0, 0, 1, 16, 1, q);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_latch();
    logic [31:0] q;
    rd(CMD_RD_SR1, q);
    `CHK("status low reset", 16'h0000, q[15:0])
    rd(CMD_RD_SR2, q);
    `CHK("status high reset", 16'h0000, q[15:0])
    fr(CMD_WR_EN, '0, 0, 1, 0, 1, q);
    rd(CMD_RD_SR1, q);
    `CHK("latch set", 8'h02, q[7:0])
    fr(CMD_WR_DIS, '0, 0, 1, 0, 1, q);
    fr(CMD_VOL_EN, '0, 0, 1, 0, 1, q);
    rd(CMD_RD_SR1, q);
    `CHK("volatile arm", 8'h00, q[7:0])
    fr(CMD_WR_DIS, '0, 0, 1, 0, 1, q);
    fr(CMD_WR_SR, {8'hff, 56'h0}, 8, 1, 0, 1, q);
    rd(CMD_RD_SR1, q);
    `CHK("disarmed write", 8'h00, q[7:0])
    $display("latch test done");
  endtask
  task automatic t_nvw();
    logic [31:0] q;
    int i;
    fr(CMD_WR_EN, '0, 0, 1, 0, 1, q);
    fr(CMD_WR_SR, {16'hffff, 48'h0}, 16, 1, 0, 1, q);
    rd(CMD_RD_SR1, q);
    `CHK("busy repeat", 16'h0303, q[15:0])
    for (i = 0; i < 20 && q[0] !== 1'b0; i++) rd(CMD_RD_SR1, q);
    if (i == 20) begin
      n_fail++;
      complete_run();
    end
    `CHK("status low write", 8'hfc, q[7:0])
    rd(CMD_RD_SR2, q);
    `CHK("status high write", 8'h7b, q[7:0])
    $display("status write test done");
  endtask
  task automatic t_lanes();
    logic [31:0] q;
    fr(CMD_MFID_Q, '0, 8, 4, 6, 4, q);
    `CHK("quad id", {MK, PT}, q[15:0])
    fr(CMD_WRAP, {32'hffffffdf, 32'h0}, 8, 4, 0, 1, q);
    `CHK("wrap bits", 3'b101, wrap_bits)
    fr(CMD_MFID_D, '0, 16, 2, 8, 2, q);
    `CHK("dual id", {MK, PT}, q[15:0])
    fr(CMD_ID, '0, 24, 1, 16, 1, q);
    `CHK("part code", {PT, PT}, q[15:0])
    fr(CMD_RD_DIO, {32'h5ac396a0, 32'h0}, 16, 2, 4, 2, q);
    `CHK("dual address", 24'h5ac396, rd_addr)
    fr(CMD_RD_QOW, {32'h00abc000, 32'h0}, 8, 4, 0, 1, q);
    `CHK("octal address", 24'h00abc0, rd_addr)
    $display("lane test done");
  endtask
  task automatic push2();
    int i;
    for (i = 0; i < 400 && rd_start !== 1'b1; i++) @(negedge clk);
    if (i == 400) begin
      n_fail++;
      complete_run();
    end
    arr_valid = 1'b1;
    arr_data = 8'ha5;
    @(negedge clk) arr_data = 8'hc3;
    @(negedge clk) arr_valid = 1'b0;
    @(negedge clk) `CHK("buffer full", 1'b0, arr_ready)
  endtask
  task automatic t_fifo();
    logic [31:0] q;
    h.open_f();
    h.send({CMD_RD_QIO, 56'h0}, 8, 1);
    fork
      h.send({32'h12345000, 32'h0}, 8, 4);
      push2();
    join
    h.recv(10, 4, q);
    `CHK("quad drive", SFC_OE_4, io_oe)
    h.close_f();
    `CHK("quad read data", 24'ha5c300, q[23:0])
    `CHK("quad address", 24'h123450, rd_addr)
    $display("buffer test done");
  endtask
  task automatic t_vol();
    logic [31:0] q;
    fr(CMD_VOL_EN, '0, 0, 1, 0, 1, q);
    fr(CMD_WR_SR, {8'hff, 56'h0}, 4, 1, 0, 1, q);
    fr(CMD_WR_SR, '0, 8, 1, 0, 1, q);
    rd(CMD_RD_SR1, q);
    `CHK("volatile low", 16'h0000, q[15:0])
    rd(CMD_RD_SR2, q);
    `CHK("volatile high", 8'h39, q[7:0])
    $display("volatile test done");
  endtask
  task automatic t_op();
    logic [31:0] q;
    arr_busy = 1'b1;
    fr(CMD_WR_EN, '0, 0, 1, 0, 1, q);
    rd(CMD_RD_SR1, q);
    `CHK("busy ignores", 8'h01, q[7:0])
    arr_busy = 1'b0;
    fr(CMD_WR_EN, '0, 0, 1, 0, 1, q);
    fr(CMD_ER4K, {24'h001000, 40'h0}, 24, 1, 0, 1, q);
    `CHK("erase op", {CMD_ER4K, 24'h001000}, {op_code, op_addr})
    @(negedge clk) op_done = 1'b1;
    @(negedge clk) op_done = 1'b0;
    rd(CMD_RD_SR1, q);
    `CHK("latch after op", 8'h00, q[7:0])
    fr(CMD_ER4K, {24'h002000, 40'h0}, 24, 1, 0, 1, q);
    `CHK("op pulses", 1, n_op)
    $display("operation test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    reset_n = 1'b0;
    {arr_busy, op_done, arr_valid, arr_data} = '0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_latch();
    t_nvw();
    t_lanes();
    t_fifo();
    t_vol();
    t_op();
    complete_run();
  end
endmodule

//--- verilog/sfc_buf.sv
// Small FIFO between the array read port and the serial output shifter.
// Assumes DEPTH is a power of two; flush empties it at once.
`timescale 1ns/1ps
module sfc_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] cnt;
    logic [AW-1:0] rd;
    logic rdy;
  } sfc_buf_t;

  sfc_buf_t s, n;
  logic push, pop;
  logic [AW-1:0] wr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    push = in_valid & s.rdy;
    pop = out_ready & (s.cnt != '0);
    wr = s.rd + s.cnt[AW-1:0];
    if (flush) begin
      n.cnt = '0;
      n.rd = '0;
    end else begin
      if (push) begin
        n.mem[wr] = in_data;
      end
      if (pop) begin
        n.rd = s.rd + 1'b1;
      end
      n.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end
    n.rdy = (n.cnt != FULL);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{rdy: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end

  assign in_ready = s.rdy;
  assign out_valid = (s.cnt != '0);
  assign out_data = s.mem[s.rd];

endmodule

//--- verilog/sfc_top.sv
// Serial flash instruction block: lane mapping, status, write enable, ID.
// Assumes the host clock runs at most a quarter of clk; array is external.
// Function
// RULE1 - Dual input: odd bits line 1, even line 0
// RULE2 - Dual output: bits 7,5,3,1 on line 1
// RULE3 - Quad input: one nibble per clock, high first
// RULE4 - Quad I/O read: four dummy clocks before data
// RULE5 - Word quad read: two dummy clocks, even address
// RULE6 - Octal word read: aligned address, no dummy
// RULE7 - Wrap bits taken from seventh nibble, lines 2-0
// RULE8 - Identifier command repeats part code until deselect
// RULE9 - Dual identifier: address, mode, then maker/part
// RULE10 - Quad identifier: two dummies, then repeated pairs
// RULE11 - Security pages at 10h, 20h, 30h offsets
// RULE12 - Write enable code sets the latch
// RULE13 - Host sets latch before any write
// RULE14 - Volatile enable arms status write, latch untouched
// RULE15 - Write disable clears latch and volatile arming
// RULE16 - Latch clears at power-up and operation end
// RULE17 - Status read shifts selected register, high first
// RULE18 - Status read allowed anytime, repeats until deselect
// RULE19 - Status write touches only writable bits
// RULE20 - Lock bits one-time programmable, never cleared (here reset loads SFC_SR2_RST into both copies, clearing them)
// RULE21 - Non-volatile status write needs latch set
// RULE22 - Volatile values lost; reset restores non-volatile (here reset loads SFC_SR1_RST/SFC_SR2_RST into both copies)
// RULE23 - Status write only after 8 or 16 bits
// RULE24 - Busy during non-volatile write, then latch clears
// RULE25 - Volatile status write never raises busy
// RULE26 - Byte boundary for writes; busy ignores commands
`timescale 1ns/1ps
module sfc_top
  import sfc_pkg::*;
#(
  parameter int unsigned TW_CYCLES = SFC_TW_CYCLES,
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h3c // Arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic arr_busy,
  input wire logic op_done,
  input wire logic arr_valid,
  input wire logic [7:0] arr_data,
  output logic arr_ready,
  output logic rd_start,
  output logic [23:0] rd_addr,
  output logic op_start,
  output logic [7:0] op_code,
  output logic [23:0] op_addr,
  output logic [2:0] wrap_bits
);

  sfc_regs_t s, n;
  sfc_dec_t d;
  logic rise, fall, cs_hi, cs_rise, is_busy, pop, op_ok, buf_valid;
  logic [7:0] buf_data, sr1_byte, src_byte, b, wr1, wr2, base1, base2, nw1, nw2;
  logic [31:0] sh_in;
  logic [5:0] step;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic sec_ok(input logic [23:0] a);
    return (a[23:16] == 8'h00) && (a[15:8] == SFC_SEC_PAGE1 ||
      a[15:8] == SFC_SEC_PAGE2 || a[15:8] == SFC_SEC_PAGE3); // RULE11
  endfunction

  function automatic sfc_dec_t decode(input logic [7:0] c, input logic qe, input logic bsy);
    sfc_dec_t r;
    r = '{st: ST_SKIP, lw: LANE_1, alen: SFC_ADDR_LEN, dlen: 4'h0, src: SRC_NONE, go: ~bsy};
    case (c)
      CMD_RD_SR1, CMD_RD_SR2: begin
        r.st = ST_OUT; // RULE18
        r.src = (c == CMD_RD_SR1) ? SRC_SR1 : SRC_SR2; // RULE17
        r.go = 1'b1;
      end
      CMD_WR_SR: r.st = ST_WDATA;
      CMD_PROG, CMD_QPROG, CMD_ER4K, CMD_ER32K, CMD_ER64K, CMD_SEC_ER, CMD_SEC_PROG: begin
        r.st = ST_ADDR;
      end
      CMD_SEC_RD: begin
        r.st = ST_ADDR;
        r.dlen = SFC_DUMMY_SEC;
        r.src = SRC_ARRAY;
      end
      CMD_ID, CMD_MFID: begin
        r.st = ST_ADDR;
        r.src = (c == CMD_ID) ? SRC_PART : SRC_PAIR; // RULE8
      end
      CMD_MFID_D, CMD_RD_DIO: begin
        r.st = ST_ADDR;
        r.lw = LANE_2;
        r.alen = SFC_ADDR_MODE_LEN;
        r.src = (c == CMD_MFID_D) ? SRC_PAIR : SRC_ARRAY; // RULE9
      end
      CMD_MFID_Q, CMD_RD_QIO, CMD_RD_QWD, CMD_RD_QOW, CMD_WRAP: begin
        r.st = ST_ADDR;
        r.lw = LANE_4;
        r.alen = SFC_ADDR_MODE_LEN;
        r.go = ~bsy & qe;
        r.src = SRC_ARRAY;
        case (c)
          CMD_MFID_Q: begin
            r.src = SRC_PAIR; // RULE10
            r.dlen = SFC_DUMMY_QID;
          end
          CMD_RD_QIO: r.dlen = SFC_DUMMY_QIO; // RULE4
          CMD_RD_QWD: r.dlen = SFC_DUMMY_QWD; // RULE5
          CMD_RD_QOW: r.dlen = 4'h0; // RULE6
          default: r.src = SRC_NONE;
        endcase
      end
      default: r.st = ST_SKIP;
    endcase
    if (!r.go) begin
      r.st = ST_SKIP; // RULE26
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Edges, status views and status-write merge
  // ----------------------------------------------------------------
  assign rise = s.sck[1] & ~s.sck[2];
  assign fall = ~s.sck[1] & s.sck[2];
  assign cs_hi = s.cs[1];
  assign cs_rise = s.cs[1] & ~s.cs[2];
  assign is_busy = s.busy | arr_busy;
  assign sr1_byte = {s.v1[7:2], s.write_enable_latch, is_busy};

  always_comb begin
    case (s.lw)
      LANE_2: begin
        sh_in = {s.sh[29:0], s.io[1][1:0]}; // RULE1
        step = 6'd2;
      end
      LANE_4: begin
        sh_in = {s.sh[27:0], s.io[1]}; // RULE3
        step = 6'd4;
      end
      default: begin
        sh_in = {s.sh[30:0], s.io[1][0]};
        step = 6'd1;
      end
    endcase
    case (s.src)
      SRC_SR1: src_byte = sr1_byte;
      SRC_SR2: src_byte = s.v2;
      SRC_PART: src_byte = PART_CODE;
      SRC_PAIR: src_byte = s.idsel ? PART_CODE : MAKER_CODE;
      SRC_ARRAY: src_byte = buf_valid ? buf_data : 8'h00;
      default: src_byte = 8'h00;
    endcase
    b = (s.ocnt == 4'h0) ? src_byte : s.osh;
    base1 = s.varm ? s.v1 : s.nv1;
    base2 = s.varm ? s.v2 : s.nv2;
    wr1 = (s.tot == SFC_WRSR_LONG) ? s.sh[15:8] : s.sh[7:0];
    wr2 = (s.tot == SFC_WRSR_LONG) ? s.sh[7:0] : (base2 & ~SFC_SR2_CLR8_MASK); // RULE23
    nw1 = (base1 & ~SFC_SR1_WR_MASK) | (wr1 & SFC_SR1_WR_MASK); // RULE19
    nw2 = (base2 & ~SFC_SR2_WR_MASK) | (wr2 & SFC_SR2_WR_MASK) |
      ((s.v2 | s.nv2) & SFC_SR2_OTP_MASK); // RULE20
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    d = decode(sh_in[7:0], s.v2[SFC_QE_BIT], is_busy);
    pop = 1'b0;
    op_ok = 1'b0;
    n.sck = {s.sck[1:0], sclk};
    n.cs = {s.cs[1:0], cs_n};
    n.io = {s.io[0], io_in};
    n.rd_start = 1'b0;
    n.op_start = 1'b0;
    if (s.busy) begin
      if (s.bcnt == 16'h0000) begin
        n.busy = 1'b0; // RULE24
        n.nv1 = s.p1;
        n.nv2 = s.p2;
        n.v1 = s.p1;
        n.v2 = s.p2;
        n.write_enable_latch = 1'b0; // RULE16
      end else begin
        n.bcnt = s.bcnt - 16'd1;
      end
    end
    if (op_done) begin
      n.write_enable_latch = 1'b0; // RULE16
    end
    if (cs_hi) begin
      n.state = ST_CMD;
      n.lw = LANE_1;
      n.cnt = '0;
      n.ocnt = '0;
      n.tot = '0;
      n.bnd = '0;
      n.idsel = 1'b0;
      n.io_oe = '0;
      n.io_out = '0;
      n.go = 1'b0;
      if (cs_rise && s.go) begin
        case (s.cmd)
          CMD_WR_EN: begin
            if (s.tot == SFC_CMD_LEN) begin
              n.write_enable_latch = 1'b1; // RULE12
            end
          end
          CMD_WR_DIS: begin
            if (s.tot == SFC_CMD_LEN) begin
              n.write_enable_latch = 1'b0; // RULE15
              n.varm = 1'b0;
            end
          end
          CMD_VOL_EN: begin
            if (s.tot == SFC_CMD_LEN) begin
              n.varm = 1'b1; // RULE14
            end
          end
          CMD_WR_SR: begin
            if (s.tot == SFC_WRSR_SHORT || s.tot == SFC_WRSR_LONG) begin // RULE23
              if (s.varm) begin
                n.v1 = nw1; // RULE25
                n.v2 = nw2;
                n.varm = 1'b0;
              end else if (s.write_enable_latch) begin // RULE21
                n.p1 = nw1;
                n.p2 = nw2;
                n.busy = 1'b1; // RULE24
                n.bcnt = 16'(TW_CYCLES - 1);
              end
            end
          end
          CMD_CHIP_ER, CMD_CHIP_ER2: op_ok = (s.tot == SFC_CMD_LEN);
          CMD_ER4K, CMD_ER32K, CMD_ER64K: op_ok = (s.tot >= SFC_ADDR_MODE_LEN);
          CMD_PROG, CMD_QPROG: op_ok = (s.tot >= SFC_PROG_MIN);
          CMD_SEC_ER: op_ok = (s.tot >= SFC_ADDR_MODE_LEN) && sec_ok(s.addr);
          CMD_SEC_PROG: op_ok = (s.tot >= SFC_PROG_MIN) && sec_ok(s.addr);
          default: op_ok = 1'b0;
        endcase
        if (op_ok && s.bnd == 3'h0 && s.write_enable_latch) begin // RULE26
          n.op_start = 1'b1;
          n.op_code = s.cmd;
          n.op_addr = s.addr;
        end
      end
    end else if (rise) begin
      n.tot = (s.tot == 6'h3f) ? s.tot : s.tot + 6'd1;
      n.bnd = s.bnd + 3'd1;
      n.sh = sh_in;
      n.cnt = s.cnt + step;
      case (s.state)
        ST_CMD: begin
          if (n.cnt == SFC_CMD_LEN) begin
            n.cmd = sh_in[7:0];
            n.go = d.go;
            n.state = d.st;
            n.lw = d.lw;
            n.alen = d.alen;
            n.dlen = d.dlen;
            n.src = d.src;
            n.cnt = '0;
          end
        end
        ST_ADDR: begin
          if (n.cnt == s.alen) begin
            n.addr = (s.alen == SFC_ADDR_LEN) ? sh_in[23:0] : sh_in[31:8];
            n.cnt = '0;
            if (s.cmd == CMD_WRAP) begin
              n.wrap = sh_in[SFC_WRAP_LSB +: 3]; // RULE7
              n.state = ST_SKIP;
            end else if (s.src == SRC_NONE || (s.cmd == CMD_SEC_RD && !sec_ok(n.addr))) begin
              n.state = ST_SKIP;
            end else begin
              if (s.src == SRC_ARRAY) begin
                n.rd_start = 1'b1;
                n.rd_addr = n.addr;
              end
              n.state = (s.dlen == 4'h0) ? ST_OUT : ST_DUMMY;
            end
          end
        end
        ST_DUMMY: begin
          n.cnt = s.cnt + 6'd1;
          if (n.cnt == {2'b00, s.dlen}) begin
            n.state = ST_OUT; // RULE4
            n.cnt = '0;
          end
        end
        default: n.cnt = s.cnt;
      endcase
    end else if (fall && s.state == ST_OUT) begin
      pop = (s.ocnt == 4'h0) && (s.src == SRC_ARRAY);
      if (s.ocnt == 4'h0 && s.src == SRC_PAIR) begin
        n.idsel = ~s.idsel; // RULE10
      end
      case (s.lw)
        LANE_2: begin
          n.io_out = {2'b00, b[7:6]}; // RULE2
          n.io_oe = SFC_OE_2;
          n.osh = {b[5:0], 2'b00};
        end
        LANE_4: begin
          n.io_out = b[7:4]; // RULE4
          n.io_oe = SFC_OE_4;
          n.osh = {b[3:0], 4'h0};
        end
        default: begin
          n.io_out = {2'b00, b[7], 1'b0}; // RULE17
          n.io_oe = SFC_OE_1;
          n.osh = {b[6:0], 1'b0};
        end
      endcase
      n.ocnt = ((s.ocnt == 4'h0) ? 4'h8 : s.ocnt) - step[3:0];
    end
  end

  // Reset loads the reset constants into both volatile and non-volatile copies
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= SFC_REGS_RST; // RULE22
    end else begin
      s <= n;
    end
  end

  sfc_buf #(.W(8), .DEPTH(2)) u_buf (
    .clk(clk),
    .reset_n(reset_n),
    .flush(cs_hi),
    .in_valid(arr_valid),
    .in_data(arr_data),
    .in_ready(arr_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(pop)
  );

  assign io_out = s.io_out;
  assign io_oe = s.io_oe;
  assign rd_start = s.rd_start;
  assign rd_addr = s.rd_addr;
  assign op_start = s.op_start;
  assign op_code = s.op_code;
  assign op_addr = s.op_addr;
  assign wrap_bits = s.wrap;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] otp_v;
  logic [1:0] top_pair;
  logic out_first;
  assign otp_v = s.v2 & SFC_SR2_OTP_MASK;
  assign top_pair = b[7:6];
  assign out_first = fall && !cs_hi && s.state == ST_OUT && s.ocnt == 4'h0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence q_cmd_end(logic [7:0] c);
    cs_rise && s.go && s.cmd == c && s.tot == SFC_CMD_LEN;
  endsequence
  sequence q_wrsr_end;
    cs_rise && s.go && s.cmd == CMD_WR_SR && (s.tot == SFC_WRSR_SHORT || s.tot == SFC_WRSR_LONG);
  endsequence

  a_wel_set: assert property (q_cmd_end(CMD_WR_EN) |=> s.write_enable_latch) // RULE12
    else $error("latch not set by write enable");
  a_vol_arm: assert property ((q_cmd_end(CMD_VOL_EN) ##0 !s.write_enable_latch) |=> s.varm && !s.write_enable_latch) // RULE14
    else $error("volatile enable wrong");
  a_wr_dis: assert property (q_cmd_end(CMD_WR_DIS) |=> !s.write_enable_latch && !s.varm) // RULE15
    else $error("write disable did not clear");
  a_vol_wrsr: assert property ((q_wrsr_end ##0 s.varm) |=> !s.busy && s.v1 == $past(nw1)) // RULE25
    else $error("volatile status write wrong");
  a_nv_start: assert property ((q_wrsr_end ##0 (!s.varm && s.write_enable_latch)) |=> s.busy ##1 s.busy) // RULE21
    else $error("non-volatile write did not go busy");
  a_busy_end: assert property ($fell(s.busy) |-> !s.write_enable_latch && s.nv1 == s.v1 && s.nv2 == s.v2) // RULE24
    else $error("busy end without commit");
  a_bad_len: assert property ((cs_rise && s.go && s.cmd == CMD_WR_SR && s.tot != SFC_WRSR_SHORT
    && s.tot != SFC_WRSR_LONG) |=> !s.busy && s.v1 == $past(s.v1)) // RULE23
    else $error("status write at bad length");
  a_otp_hold: assert property ((otp_v & $past(otp_v)) == $past(otp_v)) // RULE20
    else $error("lock bit cleared");
  a_op_bound: assert property (s.op_start |-> $past(s.bnd) == 3'h0 && $past(s.write_enable_latch)) // RULE26
    else $error("operation off boundary or without latch");
  a_sr_msb: assert property ((out_first && s.src == SRC_SR1 && s.lw == LANE_1)
    |=> s.io_out[1] == $past(sr1_byte[7]) && s.io_oe == SFC_OE_1) // RULE17
    else $error("status msb not first");
  a_dual_msb: assert property ((out_first && s.lw == LANE_2)
    |=> s.io_out[1:0] == $past(top_pair)) // RULE2
    else $error("dual output pair order wrong");

endmodule
